/* include/apc_map.svh */
`ifndef APC_MAP_SVH
`define APC_MAP_SVH

// ==========================================================
// Register offsets, as seen on the plain register port
`define APC_OFS_HOME_ADJ 16'h2353
`define APC_OFS_CTRL 16'h2400
`define APC_OFS_STATUS 16'h2401
`define APC_OFS_IDX_POS 16'h2402
`define APC_OFS_HOME_POS 16'h2403
`define APC_OFS_FAST_TIME 16'h2404
`define APC_OFS_FAST_POS 16'h2405

// ==========================================================
// Control register bit positions
`define APC_CB_IDX_FALL 0
`define APC_CB_IDX_RISE 1
`define APC_CB_IDX_KEEP 2
`define APC_CB_HOME_FALL 5
`define APC_CB_HOME_KEEP 6
`define APC_CB_FAST_EN 8
`define APC_CB_FAST_NOLAP 9
`define APC_CB_FAST_KEEP 10
`define APC_CB_ZERO_IDX 12

// ==========================================================
// Status register bit positions
`define APC_SB_IDX_NEW 0
`define APC_SB_IDX_OVR 3
`define APC_SB_HOME_NEW 4
`define APC_SB_HOME_OVR 7
`define APC_SB_FAST_NEW 8
`define APC_SB_FAST_OVR 10

// ==========================================================
// Reset values and writable mask
`define APC_CTRL_RESET 16'h0000
`define APC_CTRL_MASK 16'h1767
`define APC_POS_RESET 32'h0000_0000

// ==========================================================
// Timing
`define APC_CLK_PERIOD_NS 8
`define APC_US_NS 1000

`endif

/* include/apc_pkg.sv */
// ==========================================================
// Types shared by the capture unit and its users
package apc_pkg;

	// Raw capture pins, asynchronous to clk_in
	typedef struct packed {
		logic index;
		logic home;
		logic fast;
	} apc_pins_t;

	// One register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [31:0] wdata;
	} apc_bus_req_t;

	// Homing sequencer result
	typedef struct packed {
		logic done;
		logic [31:0] adjust;
	} apc_home_res_t;

	// Sticky capture flags
	typedef struct packed {
		logic idx_new;
		logic idx_ovr;
		logic home_new;
		logic home_ovr;
		logic fast_new;
		logic fast_ovr;
	} apc_status_t;

endpackage

/* core/apc_capture.sv */
`timescale 1ns/10ps
`include "apc_map.svh"
module apc_capture (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire apc_pkg::apc_pins_t pins_in,
	input wire logic signed [31:0] position_in,
	input wire apc_pkg::apc_home_res_t home_res_in,
	input wire apc_pkg::apc_bus_req_t bus_in,
	output logic [31:0] rd_data_out,
	output logic pos_zero_out,
	output apc_pkg::apc_status_t status_out
);

	// ==========================================================
	// Constants
	localparam int US_CYCLES = `APC_US_NS / `APC_CLK_PERIOD_NS;
	localparam logic [6:0] US_LAST = 7'(US_CYCLES - 1);

	// Rising or falling transition of a synchronised pin
	function automatic logic edge_seen(input logic now, input logic prev, input logic falling);
		edge_seen = falling ? (prev & ~now) : (now & ~prev);
	endfunction

	// Register decode on the plain port
	function automatic logic reg_hit(input logic strobe, input logic [15:0] addr, input logic [15:0] ofs);
		reg_hit = strobe && (addr == ofs);
	endfunction

	// ==========================================================
	// Storage
	logic [15:0] ctrl;
	apc_pkg::apc_status_t status;
	// Each flag has its own writer; status only gathers them
	logic idx_new;
	logic idx_ovr;
	logic home_new;
	logic home_ovr;
	logic fast_new;
	logic fast_ovr;
	apc_pkg::apc_pins_t pin_meta;
	apc_pkg::apc_pins_t pin_sync;
	apc_pkg::apc_pins_t pin_prev;
	logic signed [31:0] idx_pos;
	logic signed [31:0] home_pos;
	logic signed [31:0] fast_pos;
	logic [31:0] fast_time;
	logic [31:0] home_adj;
	logic [6:0] us_div;
	logic us_tick;
	logic [31:0] us_count;

	// ==========================================================
	// Decoded events
	logic idx_rise;
	logic idx_fall;
	logic idx_hit;
	logic home_hit;
	logic fast_hit;
	logic rd_idx;
	logic rd_home;
	logic rd_fast;
	logic wr_ctrl;
	logic idx_busy;
	logic home_busy;
	logic fast_busy;
	logic idx_load;
	logic home_load;
	logic fast_load;

	// Pin edges after the synchroniser; prev is a third stage, never the first
	assign idx_rise = edge_seen(pin_sync.index, pin_prev.index, 1'b0);
	assign idx_fall = edge_seen(pin_sync.index, pin_prev.index, 1'b1);
	assign idx_hit = (idx_fall && ctrl[`APC_CB_IDX_FALL])
		|| (idx_rise && ctrl[`APC_CB_IDX_RISE]);
	assign home_hit = edge_seen(pin_sync.home, pin_prev.home, ctrl[`APC_CB_HOME_FALL]);
	assign fast_hit = ctrl[`APC_CB_FAST_EN] && edge_seen(pin_sync.fast, pin_prev.fast, 1'b0);

	// Read side effects, and the control register write decode
	assign rd_idx = reg_hit(bus_in.rd, bus_in.addr, `APC_OFS_IDX_POS);
	assign rd_home = reg_hit(bus_in.rd, bus_in.addr, `APC_OFS_HOME_POS);
	assign rd_fast = reg_hit(bus_in.rd, bus_in.addr, `APC_OFS_FAST_POS);
	assign wr_ctrl = reg_hit(bus_in.wr, bus_in.addr, `APC_OFS_CTRL);

	// A value read in this very cycle counts as read, so a new edge may replace it
	assign idx_busy = status.idx_new && !rd_idx;
	assign home_busy = status.home_new && !rd_home;
	assign fast_busy = status.fast_new && !rd_fast;

	// Keep-until-read gates the load
	assign idx_load = idx_hit && !(idx_busy && ctrl[`APC_CB_IDX_KEEP]);
	assign home_load = home_hit && !(home_busy && ctrl[`APC_CB_HOME_KEEP]);
	assign fast_load = fast_hit
		&& !(fast_busy && (ctrl[`APC_CB_FAST_KEEP] || ctrl[`APC_CB_FAST_NOLAP]));

	// ==========================================================
	// Pin synchronisers, two stages before any logic looks
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pin_meta <= '0;
			pin_sync <= '0;
			pin_prev <= '0;
		end else begin
			pin_meta <= pins_in;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// ==========================================================
	// Microsecond time base for the fast capture stamp
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			us_div <= 7'h00;
			us_tick <= 1'b0;
		end else begin
			us_tick <= (us_div == US_LAST);
			if (us_div == US_LAST) begin
				us_div <= 7'h00;
			end else begin
				us_div <= us_div + 7'h01;
			end
		end
	end

	// Free running, wraps after about 71 minutes
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			us_count <= 32'h0000_0000;
		end else if (us_tick) begin
			us_count <= us_count + 32'h0000_0001;
		end
	end

	// ==========================================================
	// Control register, reserved bits held at zero
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ctrl <= `APC_CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= bus_in.wdata[15:0] & `APC_CTRL_MASK;
		end
	end

	// ==========================================================
	// Index capture and its flags
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			idx_pos <= `APC_POS_RESET;
		end else if (idx_load) begin
			idx_pos <= position_in;
		end
	end

	// Set wins over the read clear
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			idx_new <= 1'b0;
			idx_ovr <= 1'b0;
		end else begin
			if (idx_hit) begin
				idx_new <= 1'b1;
			end else if (rd_idx) begin
				idx_new <= 1'b0;
			end
			if (idx_hit && idx_busy) begin
				idx_ovr <= 1'b1;
			end else if (rd_idx) begin
				idx_ovr <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Home switch capture and its flags
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			home_pos <= `APC_POS_RESET;
		end else if (home_load) begin
			home_pos <= position_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			home_new <= 1'b0;
			home_ovr <= 1'b0;
		end else begin
			if (home_hit) begin
				home_new <= 1'b1;
			end else if (rd_home) begin
				home_new <= 1'b0;
			end
			if (home_hit && home_busy) begin
				home_ovr <= 1'b1;
			end else if (rd_home) begin
				home_ovr <= 1'b0;
			end
		end
	end

	// ==========================================================
	// High speed capture: position and time stamp together
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			fast_pos <= `APC_POS_RESET;
			fast_time <= 32'h0000_0000;
		end else if (fast_load) begin
			fast_pos <= position_in;
			fast_time <= us_count;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			fast_new <= 1'b0;
			fast_ovr <= 1'b0;
		end else begin
			if (fast_hit) begin
				fast_new <= 1'b1;
			end else if (rd_fast) begin
				fast_new <= 1'b0;
			end
			if (fast_hit && fast_busy) begin
				fast_ovr <= 1'b1;
			end else if (rd_fast) begin
				fast_ovr <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Homing adjustment from the sequencer
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			home_adj <= 32'h0000_0000;
		end else if (home_res_in.done) begin
			home_adj <= home_res_in.adjust;
		end
	end

	// ==========================================================
	// Position zero request, one cycle per index rising edge
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pos_zero_out <= 1'b0;
		end else begin
			pos_zero_out <= idx_rise && ctrl[`APC_CB_ZERO_IDX];
		end
	end

	// ==========================================================
	// Read data, one cycle after the strobe; unmapped reads zero
	function automatic logic [15:0] status_word(input apc_pkg::apc_status_t s);
		logic [15:0] w;
		w = 16'h0000;
		w[`APC_SB_IDX_NEW] = s.idx_new;
		w[`APC_SB_IDX_OVR] = s.idx_ovr;
		w[`APC_SB_HOME_NEW] = s.home_new;
		w[`APC_SB_HOME_OVR] = s.home_ovr;
		w[`APC_SB_FAST_NEW] = s.fast_new;
		w[`APC_SB_FAST_OVR] = s.fast_ovr;
		status_word = w;
	endfunction

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rd_data_out <= 32'h0000_0000;
		end else if (bus_in.rd) begin
			unique case (bus_in.addr)
				`APC_OFS_HOME_ADJ: rd_data_out <= home_adj;
				`APC_OFS_CTRL: rd_data_out <= {16'h0000, ctrl};
				`APC_OFS_STATUS: rd_data_out <= {16'h0000, status_word(status)};
				`APC_OFS_IDX_POS: rd_data_out <= idx_pos;
				`APC_OFS_HOME_POS: rd_data_out <= home_pos;
				`APC_OFS_FAST_TIME: rd_data_out <= fast_time;
				`APC_OFS_FAST_POS: rd_data_out <= fast_pos;
				default: rd_data_out <= 32'h0000_0000;
			endcase
		end else begin
			rd_data_out <= 32'h0000_0000;
		end
	end

	// Status also offered as a level for local use
	// Gathered in struct order, so one driver per flag
	assign status = {idx_new, idx_ovr, home_new, home_ovr, fast_new, fast_ovr};
	assign status_out = status;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	sequence s_index_rise;
		pin_sync.index && !pin_prev.index;
	endsequence

	sequence s_zero_pulse;
		pos_zero_out ##1 !pos_zero_out;
	endsequence

	a_idx_capture_flag: assert property (idx_hit |=> status.idx_new)
		else $error("index capture did not set its flag");

	a_idx_keep_old: assert property (idx_hit && idx_busy && ctrl[`APC_CB_IDX_KEEP] |=> $stable(idx_pos))
		else $error("kept index value was overwritten");

	a_idx_load_value: assert property (idx_load |=> idx_pos == $past(position_in))
		else $error("index register missed the position");

	a_idx_read_clear: assert property (rd_idx && !idx_hit |=> !status.idx_new && !status.idx_ovr)
		else $error("index read did not clear flags");

	a_home_overrun: assert property (home_hit && home_busy |=> status.home_ovr && status.home_new)
		else $error("home overrun not flagged");

	a_fast_disabled: assert property (!ctrl[`APC_CB_FAST_EN] |=> $stable(fast_pos) && $stable(fast_time))
		else $error("fast capture moved while disabled");

	a_fast_stamp: assert property (fast_load |=> fast_time == $past(us_count) && status.fast_new)
		else $error("fast time stamp wrong");

	a_zero_on_index: assert property (s_index_rise ##0 ctrl[`APC_CB_ZERO_IDX] |=> s_zero_pulse)
		else $error("position zero pulse missing");

	a_home_adjust: assert property (home_res_in.done |=> home_adj == $past(home_res_in.adjust))
		else $error("homing adjustment not loaded");

	a_status_read: assert property (reg_hit(bus_in.rd, bus_in.addr, `APC_OFS_STATUS)
		|=> rd_data_out == {16'h0000, status_word($past(status))})
		else $error("status read data wrong");

	a_us_spacing: assert property (us_tick |=> !us_tick [*8])
		else $error("microsecond tick too frequent");

	a_idx_overrun: assert property (idx_hit && idx_busy |=> status.idx_ovr && status.idx_new)
		else $error("index overrun not flagged");

	a_home_keep_old: assert property (home_hit && home_busy && ctrl[`APC_CB_HOME_KEEP]
		|=> $stable(home_pos))
		else $error("kept home value was overwritten");

	a_fast_keep_old: assert property (fast_hit && fast_busy
		&& (ctrl[`APC_CB_FAST_KEEP] || ctrl[`APC_CB_FAST_NOLAP]) |=> $stable(fast_pos) && $stable(fast_time))
		else $error("kept fast value was overwritten");

	a_fast_overrun: assert property (fast_hit && fast_busy |=> status.fast_ovr && status.fast_new)
		else $error("fast overrun not flagged");

	a_home_load_value: assert property (home_load |=> home_pos == $past(position_in))
		else $error("home register missed the position");

	a_fast_load_value: assert property (fast_load |=> fast_pos == $past(position_in))
		else $error("fast register missed the position");

	a_home_read_clear: assert property (rd_home && !home_hit |=> !status.home_new && !status.home_ovr)
		else $error("home read did not clear flags");

endmodule // apc_capture

/* sim/apc_pins_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Far side: encoder index, home switch and fast capture pins
module apc_pins_model (
	input wire logic clk_in,
	output apc_pkg::apc_pins_t pins_out
);
	// Pins are plain levels: no pull and no release state
	initial begin
		pins_out = '0;
	end

	// Move one pin after an edge, then allow for sync and capture
	task automatic drive(input int which, input logic v);
		@(posedge clk_in);
		pins_out[which] <= v;
		repeat (6) @(posedge clk_in);
	endtask
endmodule // apc_pins_model

/* sim/test_apc_capture.sv */
`timescale 1ns/10ps
`include "apc_map.svh"
// ==========================================================
// Self-checking bench for the capture unit
module test_apc_capture;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	apc_pkg::apc_pins_t pins;
	logic signed [31:0] position_in = '0;
	apc_pkg::apc_home_res_t home_res_in = '0;
	apc_pkg::apc_bus_req_t bus_in = '0;
	logic [31:0] rd_data_out;
	logic pos_zero_out;
	apc_pkg::apc_status_t status_out;
	int errors = 0;
	int comparisons = 0;
	int cyc = 0;
	int zcnt = 0;
	logic [31:0] d;

	apc_capture u_dut (.clk_in(clk_in), .rst_in(rst_in), .pins_in(pins), .position_in(position_in),
		.home_res_in(home_res_in), .bus_in(bus_in), .rd_data_out(rd_data_out),
		.pos_zero_out(pos_zero_out), .status_out(status_out));
	apc_pins_model u_pins (.clk_in(clk_in), .pins_out(pins));

	// 125 MHz clock
	always #4 clk_in = ~clk_in;

	// Cycle count for time stamps, zero pulse count
	always @(posedge clk_in) begin
		cyc <= rst_in ? 0 : cyc + 1;
		if (pos_zero_out === 1'b1) zcnt <= zcnt + 1;
	end

	// ==========================================================
	// Bus and compare helpers
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] v);
		@(posedge clk_in);
		bus_in <= {1'b1, 1'b0, a, v};
		@(posedge clk_in);
		bus_in <= '0;
	endtask

	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [31:0] v);
		@(posedge clk_in);
		bus_in <= {1'b0, 1'b1, a, 32'h0000_0000};
		@(posedge clk_in);
		bus_in <= '0;
		#1 v = rd_data_out;
	endtask

	task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
		rd(a, d);
		chk("read", exp, d);
	endtask

	task automatic st(input logic [5:0] exp);
		chk("status", {26'h0, exp}, {26'h0, status_out});
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs;
		rchk(`APC_OFS_CTRL, 32'h0000_0000);
		rchk(`APC_OFS_HOME_ADJ, 32'h0000_0000);
		rchk(16'h2406, 32'h0000_0000);
		wr(`APC_OFS_IDX_POS, 32'h1111_1111);
		rchk(`APC_OFS_IDX_POS, 32'h0000_0000);
		wr(`APC_OFS_CTRL, 32'hffff_ffff);
		rchk(`APC_OFS_CTRL, 32'h0000_1767);
	endtask

	task automatic t_idx_fall;
		wr(`APC_OFS_CTRL, 32'h0000_0001);
		position_in <= 32'hffff_fff0;
		u_pins.drive(2, 1'b1);
		st(6'h00);
		u_pins.drive(2, 1'b0);
		st(6'h20);
		rchk(`APC_OFS_STATUS, 32'h0000_0001);
		rchk(`APC_OFS_IDX_POS, 32'hffff_fff0);
		st(6'h00);
	endtask

	// Keep mode then overwrite mode, both with a second edge
	task automatic t_idx_keep;
		wr(`APC_OFS_CTRL, 32'h0000_0006);
		position_in <= 32'h0000_0011;
		u_pins.drive(2, 1'b1);
		position_in <= 32'h0000_0022;
		u_pins.drive(2, 1'b0);
		u_pins.drive(2, 1'b1);
		st(6'h30);
		rchk(`APC_OFS_IDX_POS, 32'h0000_0011);
		st(6'h00);
		wr(`APC_OFS_CTRL, 32'h0000_0002);
		position_in <= 32'h0000_0033;
		u_pins.drive(2, 1'b0);
		u_pins.drive(2, 1'b1);
		position_in <= 32'h0000_0044;
		u_pins.drive(2, 1'b0);
		u_pins.drive(2, 1'b1);
		st(6'h30);
		rchk(`APC_OFS_IDX_POS, 32'h0000_0044);
		st(6'h00);
	endtask

	// Zero pulse on the rising index edge only
	task automatic t_zero;
		wr(`APC_OFS_CTRL, 32'h0000_1000);
		u_pins.drive(2, 1'b0);
		zcnt = 0;
		u_pins.drive(2, 1'b1);
		chk("zero pulses", 32'h1, zcnt);
		st(6'h00);
	endtask

	task automatic t_home;
		wr(`APC_OFS_CTRL, 32'h0000_0000);
		position_in <= 32'h0000_0055;
		u_pins.drive(1, 1'b1);
		st(6'h08);
		wr(`APC_OFS_CTRL, 32'h0000_0060);
		position_in <= 32'h0000_0066;
		u_pins.drive(1, 1'b0);
		st(6'h0c);
		rchk(`APC_OFS_HOME_POS, 32'h0000_0055);
		st(6'h00);
		wr(`APC_OFS_CTRL, 32'h0000_0020);
		u_pins.drive(1, 1'b1);
		st(6'h00);
		position_in <= 32'h0000_0077;
		u_pins.drive(1, 1'b0);
		rchk(`APC_OFS_HOME_POS, 32'h0000_0077);
	endtask

	task automatic t_fast;
		int t;
		wr(`APC_OFS_CTRL, 32'h0000_0000);
		u_pins.drive(0, 1'b1);
		st(6'h00);
		u_pins.drive(0, 1'b0);
		wr(`APC_OFS_CTRL, 32'h0000_0100);
		repeat (1000) @(posedge clk_in);
		position_in <= 32'h0000_00a1;
		t = cyc / 125;
		u_pins.drive(0, 1'b1);
		st(6'h02);
		rd(`APC_OFS_FAST_TIME, d);
		chk("stamp in range", 32'h1, (d + 1 >= t && d <= t + 1));
		rchk(`APC_OFS_FAST_POS, 32'h0000_00a1);
		st(6'h00);
		wr(`APC_OFS_CTRL, 32'h0000_0300);
		u_pins.drive(0, 1'b0);
		position_in <= 32'h0000_00b2;
		u_pins.drive(0, 1'b1);
		position_in <= 32'h0000_00c3;
		u_pins.drive(0, 1'b0);
		u_pins.drive(0, 1'b1);
		st(6'h03);
		rchk(`APC_OFS_FAST_POS, 32'h0000_00b2);
		st(6'h00);
		// Keep by bit10 alone, the other keep control
		wr(`APC_OFS_CTRL, 32'h0000_0500);
		u_pins.drive(0, 1'b0);
		position_in <= 32'h0000_00d4;
		u_pins.drive(0, 1'b1);
		position_in <= 32'h0000_00e5;
		u_pins.drive(0, 1'b0);
		u_pins.drive(0, 1'b1);
		st(6'h03);
		rchk(`APC_OFS_FAST_POS, 32'h0000_00d4);
		st(6'h00);
	endtask

	task automatic t_homing;
		@(posedge clk_in);
		home_res_in <= {1'b1, 32'h0000_1234};
		@(posedge clk_in);
		home_res_in <= '0;
		rchk(`APC_OFS_HOME_ADJ, 32'h0000_1234);
	endtask

	// ==========================================================
	// Verdict, run once from either ending
	task automatic conclude;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		t_regs();
		t_idx_fall();
		t_idx_keep();
		t_zero();
		t_home();
		t_fast();
		t_homing();
		conclude();
	end

	// Whole run needs about 1300 cycles; cut off well beyond
	initial begin
		repeat (20000) @(posedge clk_in);
		errors++;
		conclude();
	end
endmodule // test_apc_capture
